// ---- design/abu_cmp.sv ----
module abu_cmp #(
  parameter int W = 16
) (
  input  wire logic         en_i,
  input  wire logic         valid_i,
  input  wire logic [W-1:0] addr_i,
  input  wire logic [W-1:0] ref_i,
  output logic              hit_o
);
  assign hit_o = en_i && valid_i && (addr_i == ref_i); // RQ18
endmodule : abu_cmp

// ---- design/abu_dev.sv ----
// How it works
// RQ1: Watchdog held off in break with test level
// RQ2: Comparator stays active during wait mode
// RQ3: Break in stop exits stop, sets exit flag
// RQ4: Enable bit 7 permits breaks on match
// RQ5: Enable cleared by writing zero, or reset
// RQ6: Active flag set on address match
// RQ7: Writing one to active flag forces break
// RQ8: Software clears active flag before return
// RQ9: Address bytes held, cleared on reset
// RQ10: Exit flag shows break ended low power
// RQ11: Exit flag cleared by zero write, reset
// RQ12: Software decrements return address when flagged
// RQ13: Clear enable one allows flag clearing
// RQ14: Clear enable zero blocks flag clearing (code blocks it only in break state)
// RQ15: Match asserts breakpoint signal to core
// RQ16: Match on last cycle breaks immediately
// RQ17: Return from interrupt ends break state
// RQ18: Match needs enable and full address equality
module abu_dev #(
  parameter int AW = abu_pkg::ADDR_W
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  abu_link_if.dev         lnk,
  output logic            break_o,
  output logic            in_break_o
);
  import abu_pkg::*;

  typedef struct packed {
    abu_state_t  st;
    logic        enable;
    logic        active;
    logic [7:0]  addr_hi;
    logic [7:0]  addr_lo;
    logic        sw_exit;
    logic        clr_en;
    logic        lp_pending;
  } abu_dev_t;

  abu_dev_t cur_ff;
  abu_dev_t nxt_ff;
  logic     hit;
  logic [7:0] rdata;

  // Comparator runs in every mode, wait and stop included
  abu_cmp #(.W(AW)) u_cmp (
    .en_i    (cur_ff.enable),
    .valid_i (lnk.addr_valid),
    .addr_i  (lnk.cpu_addr),
    .ref_i   ({cur_ff.addr_hi, cur_ff.addr_lo}),
    .hit_o   (hit)
  ); // RQ2 RQ4 RQ18

  always_comb begin
    nxt_ff = cur_ff;
    // Active flag is handled through the set and clear strobes below
    if (lnk.reg_we) begin
      case (lnk.reg_idx)
        REG_CTRL_STAT: nxt_ff.enable = lnk.reg_wdata[BIT_BRK_ENABLE]; // RQ4 RQ5
        REG_ADDR_HIGH: nxt_ff.addr_hi = lnk.reg_wdata; // RQ9
        REG_ADDR_LOW:  nxt_ff.addr_lo = lnk.reg_wdata; // RQ9
        REG_LP_EXIT: begin
          if (!lnk.reg_wdata[BIT_SW_EXIT]) begin
            nxt_ff.sw_exit = 1'b0; // RQ11
          end
        end
        REG_FLAG_CLR:  nxt_ff.clr_en = lnk.reg_wdata[BIT_CLR_ENABLE]; // RQ13 RQ14
        default:       nxt_ff.clr_en = cur_ff.clr_en;
      endcase
    end
    if (hit) begin
      nxt_ff.active = 1'b1; // RQ6
    end
    // Writes go through the core's register path
    if (lnk.sw_break_req) begin
      nxt_ff.active = 1'b1; // RQ7
    end
    unique case (cur_ff.st)
      ABU_RUN: begin
        if (hit || lnk.sw_break_req) begin
          nxt_ff.lp_pending = lnk.in_stop || lnk.in_wait;
          nxt_ff.st = (lnk.instr_last || lnk.in_stop || lnk.in_wait) ? ABU_BREAK : ABU_PEND; // RQ16 RQ3
        end
      end
      ABU_PEND: begin
        // A core that went to sleep meanwhile is woken at once
        if (lnk.instr_last || lnk.in_stop || lnk.in_wait) begin
          nxt_ff.lp_pending = lnk.in_stop || lnk.in_wait;
          nxt_ff.st = ABU_BREAK; // RQ16 RQ3
        end
      end
      ABU_BREAK: begin
        if (lnk.rti_done) begin
          nxt_ff.st = ABU_RUN; // RQ17
        end
      end
      default: nxt_ff.st = ABU_RUN;
    endcase
    if (cur_ff.st != ABU_BREAK && nxt_ff.st == ABU_BREAK && nxt_ff.lp_pending) begin
      nxt_ff.sw_exit = 1'b1; // RQ3 RQ10
      nxt_ff.lp_pending = 1'b0;
    end
    // Set beats a same-cycle clear
    if (lnk.brk_clear && !(hit || lnk.sw_break_req)) begin
      nxt_ff.active = 1'b0; // RQ8
    end
    if (rst_i) begin
      nxt_ff = '0; // RQ5 RQ9 RQ11
      nxt_ff.st = ABU_RUN;
    end
  end

  always_ff @(posedge clk_i) begin
    cur_ff <= nxt_ff;
  end

  assign lnk.brk_req       = (cur_ff.st == ABU_BREAK) && !rst_i; // RQ15
  assign lnk.brk_state     = (cur_ff.st == ABU_BREAK);
  assign lnk.lp_exit       = cur_ff.sw_exit;
  assign lnk.watchdog_hold = (cur_ff.st == ABU_BREAK) && lnk.test_level; // RQ1
  assign lnk.flag_clear_ok = (cur_ff.st != ABU_BREAK) || cur_ff.clr_en; // RQ13 RQ14
  assign break_o           = cur_ff.active;
  assign in_break_o        = (cur_ff.st == ABU_BREAK);

  // Unused bits read as zero
  always_comb begin
    rdata = BYTE_ZERO;
    case (lnk.reg_idx)
      REG_CTRL_STAT: begin
        rdata[BIT_BRK_ENABLE] = cur_ff.enable; // RQ4
        rdata[BIT_BRK_ACTIVE] = cur_ff.active; // RQ6
      end
      REG_ADDR_HIGH: rdata = cur_ff.addr_hi; // RQ9
      REG_ADDR_LOW:  rdata = cur_ff.addr_lo; // RQ9
      REG_LP_EXIT:   rdata[BIT_SW_EXIT] = cur_ff.sw_exit; // RQ10
      REG_FLAG_CLR:  rdata[BIT_CLR_ENABLE] = cur_ff.clr_en;
      default:       rdata = BYTE_ZERO;
    endcase
  end

  assign lnk.reg_rdata = rdata;
endmodule : abu_dev

// Core end: classic Wishbone slave, one wait state per access
module abu_core #(
  parameter int AW = abu_pkg::ADDR_W
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic          wb_sel_i,
  input  wire logic [7:0]    wb_dat_i,
  output logic [7:0]         wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic [AW-1:0] cpu_addr_i,
  input  wire logic          addr_valid_i,
  input  wire logic          instr_last_i,
  input  wire logic          in_stop_i,
  input  wire logic          in_wait_i,
  input  wire logic          rti_done_i,
  input  wire logic          test_level_i,
  output logic               brk_req_o,
  output logic               watchdog_hold_o,
  output logic               flag_clear_ok_o,
  abu_link_if.core           lnk
);
  import abu_pkg::*;

  localparam int IDX_W = $bits(REG_CTRL_STAT);

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
    logic       tst_meta;
    logic       tst_sync;
  } abu_core_t;

  abu_core_t        cur_ff;
  abu_core_t        nxt_ff;
  logic             req;
  logic             wr_strobe;
  logic             ctrl_wr;
  logic [IDX_W-1:0] idx;
  logic [7:0]       rd_mux;

  assign req = wb_cyc_i && wb_stb_i;
  assign idx = wb_adr_i[ADDR_LSB +: IDX_W];
  // Writes land on the edge at which the master sees ack
  assign wr_strobe = req && wb_we_i && wb_sel_i && cur_ff.ack;
  assign ctrl_wr   = wr_strobe && (idx == REG_CTRL_STAT);

  always_comb begin
    rd_mux = lnk.reg_rdata;
    if (idx == REG_CORE_CTL) begin
      rd_mux = BYTE_ZERO;
      rd_mux[BIT_CORE_STOP] = in_stop_i;
      rd_mux[BIT_CORE_WAIT] = in_wait_i;
      rd_mux[BIT_CORE_TEST] = cur_ff.tst_sync;
      rd_mux[BIT_CORE_LAST] = instr_last_i;
    end
  end

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.ack = req && !cur_ff.ack;
    // Read data captured early so it stands for the whole ack cycle
    if (req && !cur_ff.ack) begin
      nxt_ff.rdata = rd_mux;
    end
    // Test level comes from a pin: two flops before use
    nxt_ff.tst_meta = test_level_i;
    nxt_ff.tst_sync = cur_ff.tst_meta;
    if (rst_i) begin
      nxt_ff = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    cur_ff <= nxt_ff;
  end

  assign lnk.reg_we       = wr_strobe && (idx != REG_CORE_CTL);
  assign lnk.reg_idx      = idx;
  assign lnk.reg_wdata    = wb_dat_i;
  assign lnk.sw_break_req = ctrl_wr && wb_dat_i[BIT_BRK_ACTIVE]; // RQ7
  assign lnk.brk_clear    = ctrl_wr && !wb_dat_i[BIT_BRK_ACTIVE]; // RQ8
  assign lnk.cpu_addr     = cpu_addr_i;
  assign lnk.addr_valid   = addr_valid_i;
  assign lnk.instr_last   = instr_last_i;
  assign lnk.in_stop      = in_stop_i;
  assign lnk.in_wait      = in_wait_i;
  assign lnk.rti_done     = rti_done_i;
  assign lnk.test_level   = cur_ff.tst_sync; // RQ1
  assign brk_req_o        = lnk.brk_req; // RQ15
  assign watchdog_hold_o  = lnk.watchdog_hold; // RQ1
  assign flag_clear_ok_o  = lnk.flag_clear_ok; // RQ13 RQ14
  assign wb_ack_o         = cur_ff.ack;
  assign wb_dat_o         = cur_ff.rdata;
endmodule : abu_core

// ---- design/abu_link_if.sv ----
interface abu_link_if;
  logic [15:0] cpu_addr;
  logic        addr_valid;
  logic        instr_last;
  logic        in_stop;
  logic        in_wait;
  logic        rti_done;
  logic        test_level;
  logic        sw_break_req;
  logic        brk_clear;
  logic        brk_req;
  logic        brk_state;
  logic        lp_exit;
  logic        watchdog_hold;
  logic        flag_clear_ok;
  logic        reg_we;
  logic [2:0]  reg_idx;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  modport dev  (input  cpu_addr, addr_valid, instr_last, in_stop, in_wait, rti_done,
                test_level, sw_break_req, brk_clear, reg_we, reg_idx, reg_wdata,
                output brk_req, brk_state, lp_exit, watchdog_hold, flag_clear_ok, reg_rdata);
  modport core (output cpu_addr, addr_valid, instr_last, in_stop, in_wait, rti_done,
                test_level, sw_break_req, brk_clear, reg_we, reg_idx, reg_wdata,
                input  brk_req, brk_state, lp_exit, watchdog_hold, flag_clear_ok, reg_rdata);
endinterface : abu_link_if

// ---- design/abu_pkg.sv ----
package abu_pkg;
  // Register indices on the core side, word addressed over Wishbone
  localparam logic [2:0] REG_CTRL_STAT = 3'h0;
  localparam logic [2:0] REG_ADDR_HIGH = 3'h1;
  localparam logic [2:0] REG_ADDR_LOW  = 3'h2;
  localparam logic [2:0] REG_LP_EXIT   = 3'h3;
  localparam logic [2:0] REG_FLAG_CLR  = 3'h4;
  localparam logic [2:0] REG_CORE_CTL  = 3'h5;
  localparam int         ADDR_LSB      = 2;
  localparam int         ADDR_W        = 16;

  // Field positions
  localparam int BIT_BRK_ENABLE = 7;
  localparam int BIT_BRK_ACTIVE = 6;
  localparam int BIT_SW_EXIT    = 1;
  localparam int BIT_CLR_ENABLE = 0;
  // Core control register bits (low-power modes, test level and last cycle)
  localparam int BIT_CORE_STOP  = 0;
  localparam int BIT_CORE_WAIT  = 1;
  localparam int BIT_CORE_TEST  = 2;
  localparam int BIT_CORE_LAST  = 3;

  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [15:0] VEC_NORMAL = 16'hFFFC;
  localparam logic [15:0] VEC_MONIT  = 16'hFEFC;

  typedef enum logic [1:0] {
    ABU_RUN   = 2'b00,
    ABU_PEND  = 2'b01,
    ABU_BREAK = 2'b11
  } abu_state_t;
endpackage : abu_pkg

// ---- sim/abu_properties.sv ----
module abu_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_stop,
  input wire logic instr_last,
  input wire logic flag_clear_ok,
  input wire logic in_wait,
  input wire logic rti_done,
  input wire logic test_level,
  input wire logic sw_break_req,
  input wire logic brk_req,
  input wire logic brk_state,
  input wire logic lp_exit,
  input wire logic watchdog_hold
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_wdog_held: assert property (brk_state && test_level |-> ##[0:2] watchdog_hold) else $error("wdog free");
  a_wdog_cause: assert property (watchdog_hold |-> brk_state || $past(brk_state)) else $error("wdog held");
  a_sw_break: assert property ($rose(sw_break_req) && (instr_last || in_stop || in_wait) |-> ##[0:4] brk_state)
    else $error("no sw break");
  a_wait_break: assert property (in_wait && $rose(sw_break_req) |-> ##[0:4] brk_req || brk_state) else $error("wait");
  a_stop_exit: assert property ($rose(brk_state) && $past(in_stop) |-> lp_exit) else $error("no stop exit");
  a_req_follows: assert property (brk_state |-> brk_req) else $error("no break request");
  a_gate_open: assert property (!brk_state |-> flag_clear_ok) else $error("clear gated");
  a_exit_cause: assert property ($rose(lp_exit) |-> brk_state || $past(brk_state)) else $error("bad exit");
  a_rti_ends: assert property (rti_done && brk_state |-> ##[1:4] !brk_state) else $error("rti");
  a_reset_clear: assert property ($fell(rst_i) |-> !brk_state && !lp_exit) else $error("not cleared");
  c_break: cover property ($rose(brk_state));
  c_stop: cover property (brk_state && in_stop);
  c_rti: cover property ($fell(brk_state));
endmodule // abu_properties

// ---- sim/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import abu_pkg::*;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        wb_cyc = 1'h0;
  logic        wb_stb = 1'h0;
  logic        wb_we = 1'h0;
  logic [7:0]  wb_adr = 8'h00;
  logic [7:0]  wb_dat_w = 8'h00;
  logic [7:0]  wb_dat_r;
  logic        wb_ack;
  logic [15:0] cpu_addr = 16'h0000;
  logic        addr_valid = 1'h0;
  logic        instr_last = 1'h0;
  logic        in_stop = 1'h0;
  logic        in_wait = 1'h0;
  logic        rti_done = 1'h0;
  logic        test_level = 1'h0;
  logic        brk_req;
  logic        wdog;
  logic        clr_ok;
  logic        break_o;
  logic        in_break_o;
  logic [7:0]  rd;
  int          bad_count = 0;
  int          n_checks = 0;
  abu_link_if lnk();
  abu_core u_abu_core (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .wb_cyc_i        (wb_cyc),
    .wb_stb_i        (wb_stb),
    .wb_we_i         (wb_we),
    .wb_adr_i        (wb_adr),
    .wb_sel_i        (1'h1),
    .wb_dat_i        (wb_dat_w),
    .wb_dat_o        (wb_dat_r),
    .wb_ack_o        (wb_ack),
    .cpu_addr_i      (cpu_addr),
    .addr_valid_i    (addr_valid),
    .instr_last_i    (instr_last),
    .in_stop_i       (in_stop),
    .in_wait_i       (in_wait),
    .rti_done_i      (rti_done),
    .test_level_i    (test_level),
    .brk_req_o       (brk_req),
    .watchdog_hold_o (wdog),
    .flag_clear_ok_o (clr_ok),
    .lnk             (lnk)
  );
  abu_dev u_abu_dev (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk), .break_o(break_o), .in_break_o(in_break_o));
  abu_properties u_prop (.clk_i(clk_i), .rst_i(rst_i), .in_stop(lnk.in_stop), .in_wait(lnk.in_wait),
    .instr_last(lnk.instr_last), .flag_clear_ok(lnk.flag_clear_ok),
    .rti_done(lnk.rti_done), .test_level(lnk.test_level), .sw_break_req(lnk.sw_break_req),
    .brk_req(lnk.brk_req), .brk_state(lnk.brk_state), .lp_exit(lnk.lp_exit), .watchdog_hold(lnk.watchdog_hold));
  always #25 clk_i = ~clk_i;
  task automatic conclude;
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask
  // Slave latency is not assumed: wait for ack under a bound
  task automatic wb_xfer(input logic we, input logic [2:0] idx, input logic [7:0] d);
    logic got;
    got = 1'h0;
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= 8'(idx) << ADDR_LSB;
    wb_dat_w <= d;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk_i);
      got = (wb_ack === 1'h1);
    end
    rd = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_we <= 1'h0;
    if (!got) begin
      bad_count++;
      conclude();
    end
    @(posedge clk_i);
  endtask
  task automatic wb_wr(input logic [2:0] idx, input logic [7:0] d);
    wb_xfer(1'h1, idx, d);
  endtask
  task automatic wb_rd(input logic [2:0] idx, input logic [7:0] e, input string nm);
    wb_xfer(1'h0, idx, 8'h00);
    chk(nm, rd, e);
  endtask
  task automatic wait_st(input logic v);
    for (int i = 0; i < 20 && lnk.brk_state !== v; i++) begin
      @(posedge clk_i);
    end
    chk("brk_state", 8'(lnk.brk_state), 8'(v));
    if (lnk.brk_state !== v) begin
      conclude();
    end
  endtask
  task automatic return_from_interrupt;
    rti_done <= 1'h1;
    @(posedge clk_i);
    rti_done <= 1'h0;
    wait_st(1'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk("in_break_o", 8'(in_break_o), 8'h00);
    wb_rd(REG_CTRL_STAT, 8'h00, "ctrl_reset");
    wb_rd(REG_ADDR_HIGH, 8'h00, "addr_high_reset");
    wb_rd(REG_LP_EXIT, 8'h00, "lp_exit_reset");
    // Address bytes reset to zero, so this matches only if enable is ignored
    addr_valid <= 1'h1;
    instr_last <= 1'h1;
    repeat (4) @(posedge clk_i);
    chk("break_o", 8'(break_o), 8'h00);
    chk("brk_state", 8'(lnk.brk_state), 8'h00);
    wb_wr(REG_ADDR_HIGH, 8'h12);
    wb_wr(REG_ADDR_LOW, 8'h34);
    wb_rd(REG_ADDR_HIGH, 8'h12, "addr_high");
    wb_rd(REG_ADDR_LOW, 8'h34, "addr_low");
    wb_wr(REG_CTRL_STAT, 8'h80);
    cpu_addr <= 16'h1234;
    wait_st(1'h1);
    chk("brk_req", 8'(brk_req), 8'h01);
    wb_rd(REG_CTRL_STAT, 8'hC0, "ctrl_hit");
    addr_valid <= 1'h0;
    return_from_interrupt();
    wb_wr(REG_CTRL_STAT, 8'h80);
    wb_rd(REG_CTRL_STAT, 8'h80, "ctrl_cleared");
    // Match mid-instruction waits for the last cycle
    instr_last <= 1'h0;
    addr_valid <= 1'h1;
    repeat (4) @(posedge clk_i);
    chk("pend_break", 8'(in_break_o), 8'h00);
    instr_last <= 1'h1;
    wait_st(1'h1);
    addr_valid <= 1'h0;
    return_from_interrupt();
    wb_wr(REG_CTRL_STAT, 8'h00);
    wb_rd(REG_CTRL_STAT, 8'h00, "ctrl_off");
    in_stop <= 1'h1;
    test_level <= 1'h1;
    wb_wr(REG_CTRL_STAT, 8'h40);
    wait_st(1'h1);
    chk("watchdog_hold", 8'(wdog), 8'h01);
    chk("lp_exit", 8'(lnk.lp_exit), 8'h01);
    // Set flag tells the break routine to rewind its return address
    wb_rd(REG_LP_EXIT, 8'h02, "lp_exit_stop");
    chk("clear_blocked", 8'(clr_ok), 8'h00);
    wb_wr(REG_FLAG_CLR, 8'h01);
    chk("clear_allowed", 8'(clr_ok), 8'h01);
    wb_rd(REG_FLAG_CLR, 8'h01, "flag_clr");
    wb_wr(REG_LP_EXIT, 8'h00);
    wb_rd(REG_LP_EXIT, 8'h00, "lp_exit_clr");
    wb_wr(REG_CTRL_STAT, 8'h00);
    in_stop <= 1'h0;
    return_from_interrupt();
    in_wait <= 1'h1;
    wb_wr(REG_CTRL_STAT, 8'h80);
    addr_valid <= 1'h1;
    wait_st(1'h1);
    addr_valid <= 1'h0;
    wb_rd(REG_LP_EXIT, 8'h02, "lp_exit_wait");
    return_from_interrupt();
    wb_wr(REG_CTRL_STAT, 8'h40);
    wait_st(1'h1);
    return_from_interrupt();
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk("in_break_rerst", 8'(in_break_o), 8'h00);
    wb_rd(REG_CTRL_STAT, 8'h00, "ctrl_rerst");
    wb_rd(REG_ADDR_LOW, 8'h00, "addr_low_rerst");
    wb_rd(REG_LP_EXIT, 8'h00, "lp_exit_rerst");
    wb_rd(REG_CORE_CTL, 8'h0E, "core_status");
    conclude();
  end
endmodule // tb
